// ==== core/ctc_blink_div.sv ====
/*
 * field counter that gives the two cursor blink phases.
 * assumes a one-cycle frame end pulse on the character clock.
 */
`timescale 1ns/1ns
module ctc_blink_div #(
    parameter int CNT_W = 5
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic frame_end_in,
    output logic blink_fast_out,
    output logic blink_slow_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic fast;
        logic slow;
    } ctc_blink_t;

    ctc_blink_t st_r;
    ctc_blink_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (frame_end_in) begin
            st_nxt.cnt = st_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        st_nxt.fast = st_nxt.cnt[ctc_pkg::BLINK_FAST_BIT];
        st_nxt.slow = st_nxt.cnt[ctc_pkg::BLINK_SLOW_BIT];
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign blink_fast_out = st_r.fast;
    assign blink_slow_out = st_r.slow;
endmodule : ctc_blink_div

// ==== core/ctc_timing_core.sv ====
/*
 * character crt timing controller: indexed register file behind a pointer,
 * character/scan/row counters, sync, display enable, cursor, light pen and
 * transparent update addressing.
 * assumes host pins are synchronous to the character clock sys_clk_in and
 * one host access is marked by a one-cycle host_access_in pulse.
 */
// What this block does
// - binary mode puts successive characters on consecutive memory addresses from the start address.
// - row/column mode drives column count low and row count high on the address.
// - five raster outputs give scan line in row; count set by scan line register.
// - transparent mode turns raster top bit into strobe marking the update address.
// - 5-bit pointer written with select low; select high reaches pointed register.
// - 3-bit status register readable by host.
// - horizontal total holds characters per line minus one; sets line period.
// - horizontal displayed gives visible characters per line.
// - horizontal sync starts at the programmed character position.
// - write-only vertical adjust adds extra scan lines after the rows.
// - vertical displayed gives visible character rows per frame.
// - vertical sync starts at the programmed character row.
// - scan line register gives scan lines per character row.
// - cursor start and end bound the cursor scan lines.
// - cursor start bits 6:5 choose steady, off, blink 1/16 or 1/32.
// - 14-bit start address gives top-left character; rewriting it scrolls.
// - cursor shows where scan address equals cursor position within cursor lines.
// - mode bit 5 delays cursor by one character.
// - light pen rising edge copies scan address into light pen registers.
// - transparent update address increments after each update.
// - access to register 31 stores nothing, triggers update and ready flag.
// - mode bit 2 makes address pairs row/column instead of binary.
// - everything is timed from the character clock.
// - reset clears counters and outputs, keeps control registers.
// - mode bit 4 delays display enable by one character.
`timescale 1ns/1ns
module ctc_timing_core #(
    parameter logic [7:0] HSYNC_WIDTH = ctc_pkg::HSYNC_WIDTH_CHARS,
    parameter logic [4:0] VSYNC_WIDTH = ctc_pkg::VSYNC_WIDTH_LINES
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic host_access_in,
    input wire logic host_select_n_in,
    input wire logic host_read_in,
    input wire logic register_select_pin_in,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_out,
    input wire logic light_pen_strobe_in,
    output logic [13:0] display_memory_address_out,
    output logic [4:0] raster_line_address_out,
    output logic hsync_out,
    output logic vsync_out,
    output logic display_enable_out,
    output logic cursor_out
);
    // ----------------------------------------------------------------
    // state: control registers (kept over reset) and run state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] ptr;
        logic [7:0] h_total;
        logic [7:0] h_disp;
        logic [7:0] h_sync;
        logic [6:0] v_total;
        logic [4:0] v_adj;
        logic [6:0] v_disp;
        logic [6:0] v_sync;
        logic [7:0] mode;
        logic [4:0] scan;
        logic [6:0] cur_start;
        logic [4:0] cur_end;
        logic [13:0] start_addr;
        logic [13:0] cur_addr;
        logic [13:0] light_pen_strobe_addr;
        logic [13:0] upd_addr;
    } ctc_cfg_t;

    typedef struct packed {
        logic [7:0] hcnt;
        logic [4:0] raster;
        logic [6:0] row;
        logic [4:0] adj;
        logic in_adj;
        logic [4:0] vs_cnt;
        logic [13:0] ma_row;
        logic [13:0] ma;
        logic cur_d;
        logic de_d;
        logic lp_prev;
        logic upd_pend;
        logic upd_ready;
        logic light_pen_strobe_full;
        logic frame_end;
        logic [13:0] ma_o;
        logic [4:0] ra_o;
        logic hs_o;
        logic vs_o;
        logic de_o;
        logic cur_o;
        logic [7:0] dout;
        logic doe;
    } ctc_run_t;

    ctc_cfg_t cfg_r;
    ctc_cfg_t cfg_nxt;
    ctc_run_t run_r;
    ctc_run_t run_nxt;
    logic blink_fast;
    logic blink_slow;
    logic acc;
    logic wr;
    logic rd;
    logic line_end;
    logic last_line;
    logic adj_last;
    logic new_frame;
    logic rowcol;
    logic transp;
    logic de_now;
    logic hs_now;
    logic cur_en;
    logic cur_now;
    logic upd_go;
    logic vretrace;
    logic [7:0] hs_off;
    logic [4:0] ra_now;
    logic [13:0] scan_addr;
    logic [13:0] next_row_addr;

    // ----------------------------------------------------------------
    // blink phases
    // ----------------------------------------------------------------
    ctc_blink_div #(
        .CNT_W(5)
    ) u_blink (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .frame_end_in(run_r.frame_end),
        .blink_fast_out(blink_fast),
        .blink_slow_out(blink_slow)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        cfg_nxt = cfg_r;
        run_nxt = run_r;
        new_frame = 1'b0;
        acc = host_access_in && !host_select_n_in;
        wr = acc && !host_read_in;
        rd = acc && host_read_in;
        rowcol = cfg_r.mode[ctc_pkg::MODE_ROWCOL_BIT];
        transp = cfg_r.mode[ctc_pkg::MODE_TRANSPARENT_BIT];
        line_end = run_r.hcnt == cfg_r.h_total;
        last_line = ({1'b0, run_r.raster} + 6'h01) >= {1'b0, cfg_r.scan};
        adj_last = ({1'b0, run_r.adj} + 6'h01) >= {1'b0, cfg_r.v_adj};
        scan_addr = rowcol ? {run_r.row[5:0], run_r.hcnt} : run_r.ma;
        de_now = (run_r.hcnt < cfg_r.h_disp) && (run_r.row < cfg_r.v_disp) && !run_r.in_adj;
        hs_off = run_r.hcnt - cfg_r.h_sync;
        hs_now = (run_r.hcnt >= cfg_r.h_sync) && (hs_off < HSYNC_WIDTH);
        ra_now = run_r.in_adj ? run_r.adj : run_r.raster;
        vretrace = (run_r.vs_cnt != 5'h00) || (run_r.row >= cfg_r.v_disp) || run_r.in_adj;
        case (cfg_r.cur_start[6:5])
            ctc_pkg::CUR_MODE_STEADY: cur_en = 1'b1;
            ctc_pkg::CUR_MODE_OFF: cur_en = 1'b0;
            ctc_pkg::CUR_MODE_BLINK16: cur_en = blink_fast;
            ctc_pkg::CUR_MODE_BLINK32: cur_en = blink_slow;
            default: cur_en = 1'b0;
        endcase
        cur_now = de_now && cur_en && (scan_addr == cfg_r.cur_addr)
            && (ra_now >= cfg_r.cur_start[4:0]) && (ra_now <= cfg_r.cur_end);
        upd_go = run_r.upd_pend && (!transp || !de_now);
        next_row_addr = run_r.ma_row + {6'h00, cfg_r.h_disp};

        // character and scan counters, all on the character clock
        run_nxt.frame_end = 1'b0;
        run_nxt.hcnt = line_end ? 8'h00 : run_r.hcnt + 8'h01;
        run_nxt.ma = run_r.ma + 14'h0001;
        if (line_end) begin
            run_nxt.ma = run_r.ma_row;
            if (run_r.in_adj) begin
                if (adj_last) begin
                    new_frame = 1'b1;
                end else begin
                    run_nxt.adj = run_r.adj + 5'h01;
                end
            end else if (last_line) begin
                run_nxt.raster = 5'h00;
                if (run_r.row == cfg_r.v_total) begin
                    if (cfg_r.v_adj == 5'h00) begin
                        new_frame = 1'b1;
                    end else begin
                        run_nxt.in_adj = 1'b1;
                        run_nxt.adj = 5'h00;
                    end
                end else begin
                    run_nxt.row = run_r.row + 7'h01;
                    run_nxt.ma_row = next_row_addr;
                    run_nxt.ma = next_row_addr;
                end
            end else begin
                run_nxt.raster = run_r.raster + 5'h01;
            end
        end
        if (new_frame) begin
            run_nxt.in_adj = 1'b0;
            run_nxt.adj = 5'h00;
            run_nxt.row = 7'h00;
            run_nxt.raster = 5'h00;
            run_nxt.ma_row = cfg_r.start_addr;
            run_nxt.ma = cfg_r.start_addr;
            run_nxt.frame_end = 1'b1;
        end

        // vertical sync
        if ((run_r.row == cfg_r.v_sync) && (run_r.raster == 5'h00) && (run_r.hcnt == 8'h00)
                && !run_r.in_adj && (run_r.vs_cnt == 5'h00)) begin
            run_nxt.vs_cnt = VSYNC_WIDTH;
        end else if ((run_r.hcnt == 8'h00) && (run_r.vs_cnt != 5'h00)) begin
            run_nxt.vs_cnt = run_r.vs_cnt - 5'h01;
        end

        // registered outputs
        run_nxt.ma_o = (transp && upd_go) ? cfg_r.upd_addr : scan_addr;
        run_nxt.ra_o = ra_now;
        if (transp) begin
            run_nxt.ra_o[4] = upd_go;
        end
        run_nxt.hs_o = hs_now;
        run_nxt.vs_o = run_r.vs_cnt != 5'h00;
        run_nxt.de_d = de_now;
        run_nxt.de_o = cfg_r.mode[ctc_pkg::MODE_DE_SKEW_BIT] ? run_r.de_d : de_now;
        run_nxt.cur_d = cur_now;
        run_nxt.cur_o = cfg_r.mode[ctc_pkg::MODE_CURSOR_SKEW_BIT] ? run_r.cur_d : cur_now;

        // pending update performed at once, or only during blanking in transparent mode
        if (upd_go) begin
            cfg_nxt.upd_addr = cfg_r.upd_addr + 14'h0001;
            run_nxt.upd_pend = 1'b0;
        end

        // light pen capture
        run_nxt.lp_prev = light_pen_strobe_in;

        // host access through the pointer
        run_nxt.doe = 1'b0;
        if (wr && !register_select_pin_in) begin
            cfg_nxt.ptr = host_data_in[4:0];
        end
        if (wr && register_select_pin_in) begin
            case (cfg_r.ptr)
                ctc_pkg::REG_HORIZONTAL_TOTAL: cfg_nxt.h_total = host_data_in;
                ctc_pkg::REG_HORIZONTAL_DISPLAYED: cfg_nxt.h_disp = host_data_in;
                ctc_pkg::REG_HORIZONTAL_SYNC_POSITION: cfg_nxt.h_sync = host_data_in;
                ctc_pkg::REG_VERTICAL_TOTAL: cfg_nxt.v_total = host_data_in[6:0];
                ctc_pkg::REG_VERTICAL_TOTAL_ADJUST: cfg_nxt.v_adj = host_data_in[4:0];
                ctc_pkg::REG_VERTICAL_DISPLAYED: cfg_nxt.v_disp = host_data_in[6:0];
                ctc_pkg::REG_VERTICAL_SYNC_POSITION: cfg_nxt.v_sync = host_data_in[6:0];
                ctc_pkg::REG_MODE_CONTROL: cfg_nxt.mode = host_data_in;
                ctc_pkg::REG_SCAN_LINES_PER_ROW: cfg_nxt.scan = host_data_in[4:0];
                ctc_pkg::REG_CURSOR_START_LINE: cfg_nxt.cur_start = host_data_in[6:0];
                ctc_pkg::REG_CURSOR_END_LINE: cfg_nxt.cur_end = host_data_in[4:0];
                ctc_pkg::REG_DISPLAY_START_HIGH: cfg_nxt.start_addr[13:8] = host_data_in[5:0];
                ctc_pkg::REG_DISPLAY_START_LOW: cfg_nxt.start_addr[7:0] = host_data_in;
                ctc_pkg::REG_CURSOR_POSITION_HIGH: cfg_nxt.cur_addr[13:8] = host_data_in[5:0];
                ctc_pkg::REG_CURSOR_POSITION_LOW: cfg_nxt.cur_addr[7:0] = host_data_in;
                ctc_pkg::REG_UPDATE_ADDRESS_HIGH: cfg_nxt.upd_addr[13:8] = host_data_in[5:0];
                ctc_pkg::REG_UPDATE_ADDRESS_LOW: cfg_nxt.upd_addr[7:0] = host_data_in;
                default: cfg_nxt.ptr = cfg_r.ptr;
            endcase
        end
        if (acc && register_select_pin_in && (cfg_r.ptr == ctc_pkg::REG_UPDATE_TRIGGER_DUMMY)) begin
            run_nxt.upd_pend = 1'b1;
            run_nxt.upd_ready = 1'b0;
        end
        if (rd) begin
            run_nxt.doe = 1'b1;
            run_nxt.dout = 8'h00;
            if (!register_select_pin_in) begin
                run_nxt.dout[ctc_pkg::STAT_UPDATE_READY_BIT] = run_r.upd_ready;
                run_nxt.dout[ctc_pkg::STAT_LIGHT_PEN_STROBE_FULL_BIT] = run_r.light_pen_strobe_full;
                run_nxt.dout[ctc_pkg::STAT_VRETRACE_BIT] = vretrace;
            end else begin
                case (cfg_r.ptr)
                    ctc_pkg::REG_HORIZONTAL_TOTAL: run_nxt.dout = cfg_r.h_total;
                    ctc_pkg::REG_HORIZONTAL_DISPLAYED: run_nxt.dout = cfg_r.h_disp;
                    ctc_pkg::REG_HORIZONTAL_SYNC_POSITION: run_nxt.dout = cfg_r.h_sync;
                    ctc_pkg::REG_VERTICAL_TOTAL: run_nxt.dout = {1'b0, cfg_r.v_total};
                    ctc_pkg::REG_VERTICAL_DISPLAYED: run_nxt.dout = {1'b0, cfg_r.v_disp};
                    ctc_pkg::REG_VERTICAL_SYNC_POSITION: run_nxt.dout = {1'b0, cfg_r.v_sync};
                    ctc_pkg::REG_MODE_CONTROL: run_nxt.dout = cfg_r.mode;
                    ctc_pkg::REG_SCAN_LINES_PER_ROW: run_nxt.dout = {3'h0, cfg_r.scan};
                    ctc_pkg::REG_CURSOR_START_LINE: run_nxt.dout = {1'b0, cfg_r.cur_start};
                    ctc_pkg::REG_CURSOR_END_LINE: run_nxt.dout = {3'h0, cfg_r.cur_end};
                    ctc_pkg::REG_DISPLAY_START_HIGH: run_nxt.dout = {2'h0, cfg_r.start_addr[13:8]};
                    ctc_pkg::REG_DISPLAY_START_LOW: run_nxt.dout = cfg_r.start_addr[7:0];
                    ctc_pkg::REG_CURSOR_POSITION_HIGH: run_nxt.dout = {2'h0, cfg_r.cur_addr[13:8]};
                    ctc_pkg::REG_CURSOR_POSITION_LOW: run_nxt.dout = cfg_r.cur_addr[7:0];
                    ctc_pkg::REG_LIGHT_PEN_HIGH: run_nxt.dout = {2'h0, cfg_r.light_pen_strobe_addr[13:8]};
                    ctc_pkg::REG_LIGHT_PEN_LOW: run_nxt.dout = cfg_r.light_pen_strobe_addr[7:0];
                    ctc_pkg::REG_UPDATE_ADDRESS_HIGH: run_nxt.dout = {2'h0, cfg_r.upd_addr[13:8]};
                    ctc_pkg::REG_UPDATE_ADDRESS_LOW: run_nxt.dout = cfg_r.upd_addr[7:0];
                    default: run_nxt.dout = 8'h00;
                endcase
                if (cfg_r.ptr == ctc_pkg::REG_LIGHT_PEN_LOW) begin
                    run_nxt.light_pen_strobe_full = 1'b0;
                end
            end
        end

        // hardware sets win over host clears
        if (upd_go) begin
            run_nxt.upd_ready = 1'b1;
        end
        if (light_pen_strobe_in && !run_r.lp_prev) begin
            cfg_nxt.light_pen_strobe_addr = scan_addr;
            run_nxt.light_pen_strobe_full = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        cfg_r <= cfg_nxt;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_r <= '0;
        end else begin
            run_r <= run_nxt;
        end
    end

    assign display_memory_address_out = run_r.ma_o;
    assign raster_line_address_out = run_r.ra_o;
    assign hsync_out = run_r.hs_o;
    assign vsync_out = run_r.vs_o;
    assign display_enable_out = run_r.de_o;
    assign cursor_out = run_r.cur_o;
    assign host_data_out = run_r.dout;
    assign host_data_oe_out = run_r.doe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_ptr_write;
        wr && !register_select_pin_in;
    endsequence

    sequence s_de_skewed;
        de_now && cfg_r.mode[ctc_pkg::MODE_DE_SKEW_BIT] && $stable(cfg_r.mode);
    endsequence

    AST_LINE_WRAP: assert property (line_end |=> run_r.hcnt == 8'h00)
        else $error("character counter did not wrap at line end");
    AST_PTR_LOAD: assert property (s_ptr_write |=> cfg_r.ptr == $past(host_data_in[4:0]))
        else $error("pointer not loaded");
    AST_DE_PLAIN: assert property ((de_now && !cfg_r.mode[ctc_pkg::MODE_DE_SKEW_BIT]) |=> display_enable_out)
        else $error("display enable missing");
    AST_DE_SKEW: assert property (s_de_skewed ##1 cfg_r.mode[ctc_pkg::MODE_DE_SKEW_BIT] |=> display_enable_out)
        else $error("skewed display enable missing");
    AST_HSYNC_START: assert property ((run_r.hcnt == cfg_r.h_sync) |=> hsync_out)
        else $error("hsync not at programmed position");
    AST_STROBE_ADDR: assert property ((transp && upd_go) |=> raster_line_address_out[4]
        && display_memory_address_out == $past(cfg_r.upd_addr))
        else $error("strobe without update address");
    AST_UPD_INC: assert property ((upd_go && !(wr && register_select_pin_in)) |=>
        cfg_r.upd_addr == $past(cfg_r.upd_addr) + 14'h0001)
        else $error("update address did not advance");
    AST_TRIGGER: assert property ((acc && register_select_pin_in
        && cfg_r.ptr == ctc_pkg::REG_UPDATE_TRIGGER_DUMMY) |=> run_r.upd_pend ##[0:600] run_r.upd_ready)
        else $error("update trigger lost");
    AST_LIGHT_PEN_STROBE: assert property ((light_pen_strobe_in && !run_r.lp_prev) |=>
        cfg_r.light_pen_strobe_addr == $past(scan_addr) && run_r.light_pen_strobe_full)
        else $error("light pen address not captured");
    AST_CUR_OFF: assert property ((cfg_r.cur_start[6:5] == ctc_pkg::CUR_MODE_OFF)[*3] |-> !cursor_out)
        else $error("cursor shown while off");
endmodule : ctc_timing_core

// ==== pkg/ctc_pkg.sv ====
/*
 * constants for the character crt timing controller: register indices,
 * mode and status bit positions, cursor modes and default sync widths.
 * assumes one 8-bit host data path and one character clock.
 */
package ctc_pkg;
    // ----------------------------------------------------------------
    // register indices reached through the pointer
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_HORIZONTAL_TOTAL = 5'h00;
    localparam logic [4:0] REG_HORIZONTAL_DISPLAYED = 5'h01;
    localparam logic [4:0] REG_HORIZONTAL_SYNC_POSITION = 5'h02;
    localparam logic [4:0] REG_VERTICAL_TOTAL = 5'h04;
    localparam logic [4:0] REG_VERTICAL_TOTAL_ADJUST = 5'h05;
    localparam logic [4:0] REG_VERTICAL_DISPLAYED = 5'h06;
    localparam logic [4:0] REG_VERTICAL_SYNC_POSITION = 5'h07;
    localparam logic [4:0] REG_MODE_CONTROL = 5'h08;
    localparam logic [4:0] REG_SCAN_LINES_PER_ROW = 5'h09;
    localparam logic [4:0] REG_CURSOR_START_LINE = 5'h0a;
    localparam logic [4:0] REG_CURSOR_END_LINE = 5'h0b;
    localparam logic [4:0] REG_DISPLAY_START_HIGH = 5'h0c;
    localparam logic [4:0] REG_DISPLAY_START_LOW = 5'h0d;
    localparam logic [4:0] REG_CURSOR_POSITION_HIGH = 5'h0e;
    localparam logic [4:0] REG_CURSOR_POSITION_LOW = 5'h0f;
    localparam logic [4:0] REG_LIGHT_PEN_HIGH = 5'h10;
    localparam logic [4:0] REG_LIGHT_PEN_LOW = 5'h11;
    localparam logic [4:0] REG_UPDATE_ADDRESS_HIGH = 5'h12;
    localparam logic [4:0] REG_UPDATE_ADDRESS_LOW = 5'h13;
    localparam logic [4:0] REG_UPDATE_TRIGGER_DUMMY = 5'h1f;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MODE_ROWCOL_BIT = 2;
    localparam int MODE_TRANSPARENT_BIT = 3;
    localparam int MODE_DE_SKEW_BIT = 4;
    localparam int MODE_CURSOR_SKEW_BIT = 5;
    localparam int STAT_UPDATE_READY_BIT = 0;
    localparam int STAT_LIGHT_PEN_STROBE_FULL_BIT = 1;
    localparam int STAT_VRETRACE_BIT = 2;
    localparam int BLINK_FAST_BIT = 3;
    localparam int BLINK_SLOW_BIT = 4;
    // ----------------------------------------------------------------
    // cursor modes in cursor start bits 6:5
    // ----------------------------------------------------------------
    localparam logic [1:0] CUR_MODE_STEADY = 2'h0;
    localparam logic [1:0] CUR_MODE_OFF = 2'h1;
    localparam logic [1:0] CUR_MODE_BLINK16 = 2'h2;
    localparam logic [1:0] CUR_MODE_BLINK32 = 2'h3;
    // ----------------------------------------------------------------
    // sync widths and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] HSYNC_WIDTH_CHARS = 8'h08;
    localparam logic [4:0] VSYNC_WIDTH_LINES = 5'h10;
    localparam logic [4:0] BLINK_COUNT_RESET = 5'h00;
endpackage : ctc_pkg

// ==== sim/crt_display_timing_controller_test.sv ====
/* bench for the crt timing core; assumes a 25 MHz character clock and a tiny programmed screen */
`timescale 1ns/1ns
module crt_display_timing_controller_test;
    logic clk = 1'b0;
    logic rstn, acc, sn, rd, sel, hs, vs, de, cur, oe;
    logic lp = 1'b0;
    logic [7:0] wd, rdat, q;
    logic [13:0] ma;
    logic [4:0] ra;
    logic [159:0] cfg = 160'h3f_00_00_00_11_00_10_00_01_01_03_00_02_02_01_02_00_06_04_09;
    int error_cnt = 0, checks_done = 0, ncur;
    ctc_timing_core #(.HSYNC_WIDTH(8'h02), .VSYNC_WIDTH(5'h02)) DUT (.sys_clk_in(clk), .rstn_in(rstn),
        .host_access_in(acc), .host_select_n_in(sn), .host_read_in(rd), .register_select_pin_in(sel),
        .host_data_in(wd), .host_data_out(rdat), .host_data_oe_out(oe), .light_pen_strobe_in(lp),
        .display_memory_address_out(ma), .raster_line_address_out(ra), .hsync_out(hs), .vsync_out(vs),
        .display_enable_out(de), .cursor_out(cur));
    ctc_host_bfm host (.sys_clk_in(clk), .host_data_in(rdat), .host_access_out(acc), .host_select_n_out(sn),
        .host_read_out(rd), .register_select_pin_out(sel), .host_data_out(wd));
    initial forever #20 clk = ~clk;
    initial #1000000 test_done(1);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        error_cnt += (got !== exp);
        if (got !== exp) $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    endtask : chk
    task automatic test_done(input int late);
        error_cnt += late;
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic watch(input logic rc, input int n);
        int th = -1;
        int tv = -1;
        int run = -100;
        logic [16:0] p;
        p = {vs, hs, de, ma};
        ncur = 0;
        for (int c = 0; c < n; c++) begin
            @(posedge clk) #1;
            if (hs && !p[15] && th >= 0) chk(c - th, 10);
            if (!hs && p[15] && th >= 0) chk(c - th, 2);
            if (vs && !p[16]) chk(ma, rc ? 14'h0201 : 14'h0019);
            if (vs && !p[16] && tv >= 0) chk(c - tv, 100);
            if (!vs && p[16] && tv >= 0) chk(c - tv, 20);
            if (!de && p[14] && run >= 0) chk({run[7:0], ra <= 5'h02}, {8'h04, 1'b1});
            if (de && p[14] && !rc) chk(ma, p[13:0] + 14'h1);
            if (rc && de) chk(ma[7:0] < 8'h04 && ma[13:8] < 6'h02, 1);
            if (cur) chk({ma, ra}, {14'h0011, 5'h01});
            th = (hs && !p[15]) ? c : th;
            tv = (vs && !p[16]) ? c : tv;
            run = de ? run + 1 : (p[14] ? 0 : run);
            ncur += cur;
            p = {vs, hs, de, ma};
        end
    endtask : watch
    task automatic t_cursor;
        for (int m = 1; m < 5; m++) begin
            host.acc(5'h0a, 1'b0, {1'b0, m[1:0], 5'h01}, q);
            watch(1'b0, 3200);
            chk(ncur, m[1:0] == 2'h0 ? 32 : m[1:0] == 2'h1 ? 0 : 16);
        end
    endtask : t_cursor
    task automatic t_reset;
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({oe, ma, ra, hs, vs, de, cur}, 24'h0);
        @(posedge clk) rstn <= 1'b1;
        host.acc(5'h00, 1'b1, 8'h00, q);
        chk({q, oe}, {8'h09, 1'b1});
        repeat (100) @(posedge clk);
    endtask : t_reset
    task automatic t_skew;
        logic pd = 1'b1;
        host.acc(5'h08, 1'b0, 8'h30, q);
        ncur = 0;
        repeat (200) begin
            @(posedge clk) #1;
            if (cur) chk({ma, ra}, {14'h0012, 5'h01});
            if (de && !pd) chk(ma[1:0], 2'h1);
            ncur += cur;
            pd = de;
        end
        chk(ncur, 2);
    endtask : t_skew
    task automatic t_update;
        int n = 0;
        host.acc(5'h1f, 1'b0, 8'h00, q);
        host.cyc(1'b0, 1'b1, 8'h00, q);
        chk(q[0], 1'b1);
        host.acc(5'h13, 1'b1, 8'h00, q);
        chk(q, 8'h40);
        host.acc(5'h08, 1'b0, 8'h08, q);
        host.acc(5'h1f, 1'b0, 8'h00, q);
        repeat (20) begin
            @(posedge clk) #1;
            if (ra[4]) chk(ma, 14'h0040);
            n += ra[4];
        end
        chk(n, 1);
        host.acc(5'h13, 1'b1, 8'h00, q);
        chk(q, 8'h41);
    endtask : t_update
    task automatic t_light_pen_strobe;
        logic [13:0] e;
        @(posedge clk) lp <= 1'b1;
        @(posedge clk) lp <= 1'b0;
        #1 e = ma;
        host.cyc(1'b0, 1'b1, 8'h00, q);
        chk(q[1], 1'b1);
        host.acc(5'h10, 1'b1, 8'h00, q);
        chk(q, {2'h0, e[13:8]});
        host.acc(5'h11, 1'b1, 8'h00, q);
        chk(q, e[7:0]);
        host.cyc(1'b0, 1'b1, 8'h00, q);
        chk(q[1], 1'b0);
    endtask : t_light_pen_strobe
    initial begin
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 20; i++) host.acc(i[4:0], 1'b0, cfg[8*i +: 8], q);
        t_reset();
        t_cursor();
        t_skew();
        host.acc(5'h08, 1'b0, 8'h04, q);
        watch(1'b1, 400);
        t_update();
        t_light_pen_strobe();
        test_done(0);
    end
endmodule : crt_display_timing_controller_test

// ==== sim/ctc_host_bfm.sv ====
/* host bus model on the register pins; assumes the core samples them on the rising clock edge */
`timescale 1ns/1ns
module ctc_host_bfm (
    input wire logic sys_clk_in,
    input wire logic [7:0] host_data_in,
    output logic host_access_out,
    output logic host_select_n_out,
    output logic host_read_out,
    output logic register_select_pin_out,
    output logic [7:0] host_data_out
);
    initial {host_access_out, host_select_n_out, host_read_out, register_select_pin_out, host_data_out} = 12'h400;
    task automatic cyc(input logic sel, input logic rd, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk_in) {host_access_out, host_select_n_out, host_read_out} <= {2'h2, rd};
        {register_select_pin_out, host_data_out} <= {sel, d};
        @(posedge sys_clk_in) {host_access_out, host_select_n_out, host_data_out} <= {2'h1, ~d};
        #1 q = host_data_in;
    endtask : cyc
    task automatic acc(input logic [4:0] idx, input logic rd, input logic [7:0] d, output logic [7:0] q);
        cyc(1'b0, 1'b0, {3'h0, idx}, q);
        cyc(1'b1, rd, d, q);
    endtask : acc
endmodule : ctc_host_bfm
